/* File: hpt_pkg.sv */
/*
 * Shared constants and types for the hub port transceiver tuning registers.
 * Assumes one 100 MHz APB clock domain; register indices are word indices.
 */
`default_nettype none

package hpt_pkg;

    // ---------------------------------------------------------------
    // Bus geometry
    // ---------------------------------------------------------------
    localparam int HPT_ADDR_W = 18;
    localparam int HPT_DATA_W = 32;
    localparam int HPT_IDX_W = 16;
    localparam int HPT_NUM_TRIM_PORTS = 3;
    localparam int HPT_NUM_SS_PORTS = 4;

    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    // Element 0 is port 5, element 2 is port 7
    localparam logic [2:0][15:0] HPT_DRIVE_IDX = {16'h7cca, 16'h78ca, 16'h74ca};
    localparam logic [2:0][15:0] HPT_SQUELCH_IDX = {16'h7ccc, 16'h78cc, 16'h74cc};
    localparam logic [15:0] HPT_LINK_IDX_BASE = 16'h7dc0;

    // ---------------------------------------------------------------
    // Field layout and reset values
    // ---------------------------------------------------------------
    localparam int HPT_TRIM_W = 3;
    localparam int HPT_REG_W = 8;
    localparam int HPT_LINK_STATE_LSB = 4;
    localparam int HPT_LINK_SUB_LSB = 0;
    localparam logic [7:0] HPT_DRIVE_RST = 8'h00;
    localparam logic [2:0] HPT_SQUELCH_RST = 3'h0;

    // ---------------------------------------------------------------
    // Trim and link-state encodings
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        HPT_DRV_NOMINAL = 3'b000,
        HPT_DRV_MINUS_5PCT = 3'b001,
        HPT_DRV_PLUS_10PCT = 3'b010,
        HPT_DRV_PLUS_20PCT = 3'b100
    } hpt_drive_code_e;

    typedef enum logic [2:0] {
        HPT_SQ_NOMINAL_100MV = 3'b000,
        HPT_SQ_MINUS_12P5MV = 3'b001,
        HPT_SQ_MINUS_25MV = 3'b010,
        HPT_SQ_MINUS_37P5MV = 3'b011,
        HPT_SQ_MINUS_50MV = 3'b100
    } hpt_squelch_code_e;

    typedef enum logic [3:0] {
        HPT_LS_U0 = 4'h0,
        HPT_LS_U1 = 4'h1,
        HPT_LS_U2 = 4'h2,
        HPT_LS_U3 = 4'h3,
        HPT_LS_DISABLED = 4'h4,
        HPT_LS_RX_DETECT = 4'h5,
        HPT_LS_INACTIVE = 4'h6,
        HPT_LS_POLLING = 4'h7,
        HPT_LS_RECOVERY = 4'h8,
        HPT_LS_HOT_RESET = 4'h9,
        HPT_LS_COMPLIANCE = 4'ha,
        HPT_LS_LOOPBACK = 4'hb
    } hpt_link_state_e;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        hpt_link_state_e state;
        logic [2:0] sub_state;
    } hpt_link_status_s;

    typedef struct packed {
        logic [7:0] drive;
        logic [2:0] squelch;
    } hpt_port_trim_s;

    typedef struct packed {
        hpt_port_trim_s [HPT_NUM_TRIM_PORTS-1:0] port;
        logic [31:0] prdata;
        logic pslverr;
    } hpt_state_s;

    typedef logic [HPT_NUM_TRIM_PORTS-1:0][HPT_TRIM_W-1:0] hpt_trim_vec_t;

endpackage

`default_nettype wire

/* File: hpt_tuning_regs.sv */
/*
 * APB register bank holding drive-current and squelch trims for ports 5 to 7
 * and read-only link-state status for the SuperSpeed ports.
 * Assumes an APB master on pclk; link status arrives synchronous to pclk.
 */
// Our own choice: the APB interface to the registers.
`default_nettype none

// Behaviour
// [R1] Drive trim per port, whole byte read/write
// [R2] Drive codes: nominal, -5%, +10%, +20%
// [R3] Ambiguous drive codes stored and returned unchanged
// [R4] Squelch trim per port, bits 7:3 read zero
// [R5] Squelch codes: 100 mV nominal, lowering steps
// [R6] Port 5 code 011 lowers 37.5 mV
// [R7] Link-state status uses shared code table
// [R8] Link state 7:4, sub-state 2:0, bit3 zero
// [R9] Trims reset to zero, nominal settings
module hpt_tuning_regs #(
    parameter int NUM_SS_PORTS = hpt_pkg::HPT_NUM_SS_PORTS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [hpt_pkg::HPT_ADDR_W-1:0] paddr,
    input wire logic [hpt_pkg::HPT_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [hpt_pkg::HPT_DATA_W-1:0] prdata,
    output logic pslverr,
    input wire hpt_pkg::hpt_link_status_s [NUM_SS_PORTS-1:0] ss_link_status,
    output hpt_pkg::hpt_trim_vec_t hs_drive_current_trim,
    output hpt_pkg::hpt_trim_vec_t hs_squelch_trip_trim
);
    import hpt_pkg::*;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    hpt_state_s st_r;
    hpt_state_s st_nxt;
    logic aligned;
    logic [HPT_IDX_W-1:0] word_idx;
    logic [HPT_NUM_TRIM_PORTS-1:0] drv_hit;
    logic [HPT_NUM_TRIM_PORTS-1:0] sq_hit;
    logic [NUM_SS_PORTS-1:0] lnk_hit;
    logic [HPT_NUM_TRIM_PORTS-1:0][31:0] rd_drv;
    logic [HPT_NUM_TRIM_PORTS-1:0][31:0] rd_sq;
    logic [NUM_SS_PORTS-1:0][31:0] rd_lnk;
    logic [31:0] rd_word;
    logic any_hit;
    logic setup_ph;
    logic wr_acc;

    // Registers sit one to a word, so low address bits must be zero
    assign aligned = (paddr[1:0] == 2'b00);
    assign word_idx = paddr[HPT_ADDR_W-1:2];
    assign setup_ph = psel & ~penable;
    // Write commits only in the access phase, and only with byte 0 strobed
    assign wr_acc = psel & penable & pwrite & pstrb[0];

    genvar gi;
    generate
        for (gi = 0; gi < HPT_NUM_TRIM_PORTS; gi++) begin : g_trim
            assign drv_hit[gi] = aligned && (word_idx == HPT_DRIVE_IDX[gi]);
            assign sq_hit[gi] = aligned && (word_idx == HPT_SQUELCH_IDX[gi]);
            // Whole byte returned, reserved bits included
            assign rd_drv[gi] = drv_hit[gi] ? {24'h000000, st_r.port[gi].drive} : 32'h0; // [R1] [R3]
            // Upper squelch bits always read zero
            assign rd_sq[gi] = sq_hit[gi] ? {29'h0, st_r.port[gi].squelch} : 32'h0; // [R4]
            assign hs_drive_current_trim[gi] = st_r.port[gi].drive[HPT_TRIM_W-1:0]; // [R2]
            assign hs_squelch_trip_trim[gi] = st_r.port[gi].squelch; // [R5] [R6]
        end
        for (gi = 0; gi < NUM_SS_PORTS; gi++) begin : g_link
            assign lnk_hit[gi] = aligned && (word_idx == HPT_LINK_IDX_BASE + 16'(gi));
            // Live status, bit 3 reserved as zero
            assign rd_lnk[gi] = lnk_hit[gi] ?
                {24'h000000, ss_link_status[gi].state, 1'b0, ss_link_status[gi].sub_state}
                : 32'h0; // [R7] [R8]
        end
    endgenerate

    assign any_hit = (|drv_hit) | (|sq_hit) | (|lnk_hit);

    always_comb begin
        rd_word = 32'h0;
        for (int i = 0; i < HPT_NUM_TRIM_PORTS; i++) begin
            rd_word = rd_word | rd_drv[i] | rd_sq[i];
        end
        for (int j = 0; j < NUM_SS_PORTS; j++) begin
            rd_word = rd_word | rd_lnk[j];
        end
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Answer prepared in setup, presented in access
        if (setup_ph) begin
            st_nxt.pslverr = ~any_hit;
            st_nxt.prdata = (pwrite || !any_hit) ? 32'h0 : rd_word;
        end
        // Reserved drive bits are kept, reserved squelch bits dropped
        if (wr_acc) begin
            for (int i = 0; i < HPT_NUM_TRIM_PORTS; i++) begin
                if (drv_hit[i]) begin
                    st_nxt.port[i].drive = pwdata[HPT_REG_W-1:0]; // [R1] [R3]
                end
                if (sq_hit[i]) begin
                    st_nxt.port[i].squelch = pwdata[HPT_TRIM_W-1:0]; // [R4] [R6]
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < HPT_NUM_TRIM_PORTS; i++) begin
                st_r.port[i].drive <= HPT_DRIVE_RST; // [R9]
                st_r.port[i].squelch <= HPT_SQUELCH_RST; // [R9]
            end
            // Answer cleared so no stale error shows after reset
            st_r.prdata <= 32'h0;
            st_r.pslverr <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Zero wait states
    assign pready = 1'b1;
    assign prdata = st_r.prdata;
    assign pslverr = st_r.pslverr;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [7:0] wbyte;
    assign wbyte = pwdata[7:0];

    a_drive_write_lands: assert property ( // [R1]
        wr_acc && drv_hit[0] |=> st_r.port[0].drive == $past(wbyte)
    ) else $error("port 5 drive trim write lost");

    a_drive_holds: assert property ( // [R1]
        !(wr_acc && drv_hit[1]) |=> $stable(st_r.port[1].drive)
    ) else $error("port 6 drive trim changed without write");

    a_drive_code_out: assert property ( // [R2]
        wr_acc && drv_hit[1] && pwdata[2:0] == HPT_DRV_PLUS_20PCT
        |=> hs_drive_current_trim[1] == HPT_DRV_PLUS_20PCT
    ) else $error("drive code not applied");

    a_ambig_code_kept: assert property ( // [R3]
        wr_acc && drv_hit[2] && pwdata[2:0] == 3'b101 ##1 setup_ph && !pwrite && drv_hit[2]
        |=> prdata[2:0] == 3'b101 && hs_drive_current_trim[2] == 3'b101
    ) else $error("ambiguous drive code not returned");

    a_sq_rsvd_zero: assert property ( // [R4]
        setup_ph && !pwrite && (|sq_hit) |=> prdata[31:3] == 29'h0 && !pslverr
    ) else $error("squelch reserved bits not zero");

    a_sq_write_lands: assert property ( // [R6]
        wr_acc && sq_hit[0] && pwdata[2:0] == HPT_SQ_MINUS_37P5MV
        |=> hs_squelch_trip_trim[0] == HPT_SQ_MINUS_37P5MV
    ) else $error("port 5 squelch write lost");

    a_link_read: assert property ( // [R8]
        setup_ph && !pwrite && lnk_hit[0]
        |=> prdata[7:4] == $past(ss_link_status[0].state) && !prdata[3]
            && prdata[2:0] == $past(ss_link_status[0].sub_state)
    ) else $error("link state readback wrong");

    a_unmapped_err: assert property (
        setup_ph && !any_hit |=> pslverr && prdata == 32'h0 ##1 pslverr
    ) else $error("unmapped access not flagged");

    a_reset_nominal: assert property ( // [R9]
        disable iff (1'b0) !presetn |-> hs_drive_current_trim == '0 && hs_squelch_trip_trim == '0
    ) else $error("trims not nominal in reset");

    a_reset_quiet: assert property (
        disable iff (1'b0) !presetn |-> prdata == 32'h0 && !pslverr && pready
    ) else $error("bus answer not quiet in reset");

    // ---------------------------------------------------------------
    // Checks per trim port
    // ---------------------------------------------------------------
    generate
        for (gi = 0; gi < HPT_NUM_TRIM_PORTS; gi++) begin : g_trim_chk
            a_drive_follows: assert property ( // [R2]
                wr_acc && drv_hit[gi]
                |=> hs_drive_current_trim[gi] == $past(pwdata[HPT_TRIM_W-1:0])
            ) else $error("drive trim output does not follow write");

            a_drive_kept: assert property ( // [R1]
                !(wr_acc && drv_hit[gi]) |=> $stable(st_r.port[gi].drive)
            ) else $error("drive trim changed without write");

            a_sq_follows: assert property ( // [R5]
                wr_acc && sq_hit[gi]
                |=> hs_squelch_trip_trim[gi] == $past(pwdata[HPT_TRIM_W-1:0])
            ) else $error("squelch trim output does not follow write");

            a_sq_kept: assert property ( // [R4]
                !(wr_acc && sq_hit[gi]) |=> $stable(st_r.port[gi].squelch)
            ) else $error("squelch trim changed without write");

            a_drive_readback: assert property ( // [R1]
                setup_ph && !pwrite && drv_hit[gi]
                |=> prdata == {24'h000000, $past(st_r.port[gi].drive)}
            ) else $error("drive trim readback wrong");

            a_sq_readback: assert property ( // [R4]
                setup_ph && !pwrite && sq_hit[gi]
                |=> prdata == {29'h0, $past(st_r.port[gi].squelch)}
            ) else $error("squelch trim readback wrong");
        end
    endgenerate

    // ---------------------------------------------------------------
    // Checks on the bus answer
    // ---------------------------------------------------------------
    a_answer_stands: assert property (
        !setup_ph |=> $stable(prdata) && $stable(pslverr)
    ) else $error("read data or error changed outside setup phase");

    a_write_quiet: assert property (
        setup_ph && pwrite && any_hit |=> prdata == 32'h0 && !pslverr
    ) else $error("mapped write flagged or returned data");

    a_misaligned_err: assert property (
        setup_ph && paddr[1:0] != 2'b00 |=> pslverr && prdata == 32'h0
    ) else $error("misaligned access not flagged");

    a_bad_write_kept: assert property (
        psel && penable && pwrite && !any_hit |=> $stable(st_r.port)
    ) else $error("refused write changed a trim");

    a_strobe_off_kept: assert property ( // [R1]
        psel && penable && pwrite && !pstrb[0] |=> $stable(st_r.port)
    ) else $error("write without byte strobe changed a trim");

    a_decode_onehot: assert property (
        $onehot0({drv_hit, sq_hit, lnk_hit})
    ) else $error("address decodes to two registers");

    a_setup_answers: assert property (
        setup_ph && !pwrite && any_hit |=> !pslverr
    ) else $error("mapped read flagged as error");

    a_idle_no_write: assert property (
        !psel |=> $stable(st_r.port)
    ) else $error("trim changed while bus idle");

    a_setup_no_write: assert property (
        setup_ph |=> $stable(st_r.port)
    ) else $error("trim changed in setup phase");

    // ---------------------------------------------------------------
    // Checks on link status
    // ---------------------------------------------------------------
    a_link_write_ok: assert property ( // [R8]
        setup_ph && pwrite && (|lnk_hit) |=> !pslverr && prdata == 32'h0
    ) else $error("link status write flagged as error");

    a_link_not_stored: assert property ( // [R8]
        wr_acc && (|lnk_hit) |=> $stable(st_r.port)
    ) else $error("link status write changed a trim");

    a_link_rsvd_zero: assert property ( // [R8]
        setup_ph && !pwrite && (|lnk_hit) |=> prdata[31:8] == 24'h0 && !prdata[3]
    ) else $error("link status reserved bits not zero");

    generate
        for (gi = 0; gi < NUM_SS_PORTS; gi++) begin : g_link_chk
            a_link_readback: assert property ( // [R7] [R8]
                setup_ph && !pwrite && lnk_hit[gi]
                |=> prdata[7:4] == $past(ss_link_status[gi].state)
                    && prdata[2:0] == $past(ss_link_status[gi].sub_state)
            ) else $error("link status readback wrong");
        end
    endgenerate

    // ---------------------------------------------------------------
    // Coverage
    // ---------------------------------------------------------------
    c_drive_write: cover property (wr_acc && drv_hit[2]);
    c_link_read: cover property (setup_ph && !pwrite && lnk_hit[NUM_SS_PORTS-1]);
    c_unmapped: cover property (psel && penable && pslverr);
    c_back_to_back: cover property (wr_acc ##1 setup_ph && !pwrite);
    c_sq_write: cover property (wr_acc && sq_hit[0]);

endmodule // hpt_tuning_regs

`default_nettype wire

/* File: test_hpt_tuning_regs.sv */
/*
 * Self-checking bench for the port tuning register bank, driven over APB.
 * Assumes hpt_pkg and hpt_tuning_regs are compiled before this file.
 */
`default_nettype none

module test_hpt_tuning_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import hpt_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [HPT_ADDR_W-1:0] paddr = '0;
    logic [HPT_DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'h0;
    logic pready;
    logic [HPT_DATA_W-1:0] prdata;
    logic pslverr;
    hpt_link_status_s [HPT_NUM_SS_PORTS-1:0] ss_link_status = '0;
    hpt_trim_vec_t hs_drive_current_trim;
    hpt_trim_vec_t hs_squelch_trip_trim;
    int failures = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic err;
    logic b2b = 1'b0;
    logic chained = 1'b0;

    hpt_tuning_regs #(.NUM_SS_PORTS(HPT_NUM_SS_PORTS)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ss_link_status(ss_link_status),
        .hs_drive_current_trim(hs_drive_current_trim),
        .hs_squelch_trip_trim(hs_squelch_trip_trim)
    );

    initial begin
        forever #5 pclk = ~pclk;
    end

    // ---------------------------------------------------------------
    // Bus and compare tasks
    // ---------------------------------------------------------------
    function automatic logic [17:0] adr(input logic [15:0] idx);
        return {idx, 2'b00};
    endfunction

    function automatic logic [7:0] drv_val(input int c);
        return {5'(c) ^ 5'h15, 3'(c)};
    endfunction

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic xfer(input logic [17:0] a, input logic w, input logic [7:0] d,
                        input logic [3:0] s);
        int n;
        n = 0;
        if (!chained) begin
            @(posedge pclk);
        end
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'ha5a5a5, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) failures++;
        rd = prdata;
        err = pslverr;
        chained = b2b;
        if (!b2b) begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rdchk(input string nm, input logic [17:0] a, input logic [31:0] exp,
                         input logic eerr);
        xfer(a, 1'b0, 8'h00, 4'h0);
        chk(nm, exp, rd);
        chk({nm, " error"}, {31'h0, eerr}, {31'h0, err});
    endtask

    task automatic end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        end_of_test;
    end

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        int p;
        int c;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (p = 0; p < 3; p++) begin
            rdchk("drive reset", adr(HPT_DRIVE_IDX[p]), 32'h0, 1'b0);
            rdchk("squelch reset", adr(HPT_SQUELCH_IDX[p]), 32'h0, 1'b0);
        end
        chk("drive out reset", 32'(hs_drive_current_trim), 32'h0);
        chk("squelch out reset", 32'(hs_squelch_trip_trim), 32'h0);
        $display("test reset_values done");
        for (p = 0; p < 3; p++) begin
            for (c = 0; c < 8; c++) begin
                xfer(adr(HPT_DRIVE_IDX[p]), 1'b1, drv_val(c), 4'h1);
                rdchk("drive", adr(HPT_DRIVE_IDX[p]), {24'h0, drv_val(c)}, 1'b0);
                chk("drive out", 32'(c % 8), 32'(hs_drive_current_trim[p]));
                xfer(adr(HPT_SQUELCH_IDX[p]), 1'b1, {5'h1f, 3'(c)}, 4'hf);
                rdchk("squelch", adr(HPT_SQUELCH_IDX[p]), 32'(c % 8), 1'b0);
                chk("squelch out", 32'(c % 8), 32'(hs_squelch_trip_trim[p]));
            end
        end
        $display("test trim_codes done");
        xfer(adr(HPT_DRIVE_IDX[0]), 1'b1, 8'h00, 4'he);
        rdchk("drive no strobe", adr(HPT_DRIVE_IDX[0]), {24'h0, drv_val(7)}, 1'b0);
        $display("test strobe_off done");
        b2b = 1'b1;
        xfer(adr(HPT_DRIVE_IDX[2]), 1'b1, 8'h2d, 4'h1);
        b2b = 1'b0;
        rdchk("drive back to back", adr(HPT_DRIVE_IDX[2]), 32'h0000002d, 1'b0);
        chk("drive out back to back", 32'h5, 32'(hs_drive_current_trim[2]));
        $display("test back_to_back done");
        for (c = 0; c < 12; c++) begin
            ss_link_status[c % 4] <= '{hpt_link_state_e'(c[3:0]), c[2:0] ^ 3'h5};
            xfer(adr(HPT_LINK_IDX_BASE + 16'(c % 4)), 1'b1, 8'hff, 4'hf);
            chk("link write error", 32'h0, {31'h0, err});
            rdchk("link status", adr(HPT_LINK_IDX_BASE + 16'(c % 4)),
                  {24'h0, c[3:0], 1'b0, c[2:0] ^ 3'h5}, 1'b0);
        end
        $display("test link_status done");
        rdchk("unmapped", 18'h00100, 32'h0, 1'b1);
        rdchk("misaligned", adr(HPT_DRIVE_IDX[1]) | 18'h1, 32'h0, 1'b1);
        xfer(18'h00100, 1'b1, 8'h5a, 4'hf);
        chk("unmapped write error", 32'h1, {31'h0, err});
        rdchk("drive after bad", adr(HPT_DRIVE_IDX[1]), {24'h0, drv_val(7)}, 1'b0);
        $display("test refused_access done");
        end_of_test;
    end
endmodule // test_hpt_tuning_regs

`default_nettype wire
